// [include/rcr_map.svh]
// register offsets, field positions and reset values for the rail control bank
`ifndef RCR_MAP_SVH
`define RCR_MAP_SVH

`define RCR_ADDR_W          8
`define RCR_DATA_W          8
`define RCR_OFF_STEP_A      8'h26
`define RCR_OFF_STEP_B      8'h27
`define RCR_OFF_LINEAR_A    8'h28
`define RCR_SLP_HI          5
`define RCR_SLP_LO          4
`define RCR_MODE_BIT        1
`define RCR_ON_BIT          0
`define RCR_SLP_OFF         2'h0
`define RCR_SLP_ON          2'h3
`define RCR_RO_MASK         8'hC0
`define RCR_RST_STEP_A      8'h0F
`define RCR_RST_STEP_B      8'h0D
`define RCR_RST_LINEAR_A    8'h0D
`define RCR_PIN_ONE         1'b0
`define RCR_PIN_TWO         1'b1

`endif

// [include/rcr_pkg.sv]
// types shared by the rail control bank
package rcr_pkg;

  // host port write or read request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rcr_req_t;

  // decoded control for one rail
  typedef struct packed {
    logic on;
    logic pwm;
    logic use_sleep;
  } rcr_rail_t;

  // access phase of the host port
  typedef enum logic [1:0] {
    RCR_IDLE  = 2'b00,
    RCR_WRITE = 2'b01,
    RCR_READ  = 2'b10
  } rcr_phase_t;

endpackage

// [src/rcr_rail_sel.sv]
// per-rail voltage code select and enable gating
`timescale 1ns/1ps
`default_nettype none
`include "rcr_map.svh"

module rcr_rail_sel (
  input  wire logic [7:0] ctrl,
  input  wire logic       has_mode,
  input  wire logic       pin_sel,
  input  wire logic       sleep_pin_one,
  input  wire logic       sleep_pin_two,
  input  wire logic       pin_on,
  output var rcr_pkg::rcr_rail_t rail
);

  logic slp_pin;

  // ****************************************************
  // sleep code select and on gating
  // ****************************************************
  // factory pin choice
  assign slp_pin = (pin_sel == `RCR_PIN_TWO) ? sleep_pin_two : sleep_pin_one;
  always_comb begin
    rail.use_sleep = (ctrl[`RCR_SLP_HI:`RCR_SLP_LO] == `RCR_SLP_ON) &&
                     !slp_pin;
    rail.pwm = has_mode & ctrl[`RCR_MODE_BIT];
    rail.on = ctrl[`RCR_ON_BIT] & pin_on;
  end

endmodule // rcr_rail_sel
`default_nettype wire

// [src/rcr_bank.sv]
// rail control register bank: two step-down rails and one linear rail
// Behaviour
// - sleep field 00 always selects the normal voltage code.
// - sleep field 11 selects the sleep code while the assigned pin is low.
// - the governing sleep pin per rail is a factory strap, not a register.
// - step-down mode bit 0 means automatic, 1 means forced pwm.
// - on bit 0 turns a step-down rail off regardless of control pins.
// - the linear on bit behaves the same way.
// - step-down rail a control sits at 26h with a factory reset value.
// - rail b at 27h and linear at 28h, both with factory reset values.
`timescale 1ns/1ps
`default_nettype none
`include "rcr_map.svh"

module rcr_bank #(
  parameter logic [7:0] RST_STEP_A   = `RCR_RST_STEP_A,
  parameter logic [7:0] RST_STEP_B   = `RCR_RST_STEP_B,
  parameter logic [7:0] RST_LINEAR_A = `RCR_RST_LINEAR_A,
  parameter logic [2:0] PIN_SEL      = 3'h0
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire rcr_pkg::rcr_req_t req,
  input  wire logic             sleep_pin_one,
  input  wire logic             sleep_pin_two,
  input  wire logic [2:0]       control_pin_on,
  output logic [7:0]            rdata,
  output logic                  rvalid,
  output logic                  step_down_rail_a_on,
  output logic                  step_down_rail_b_on,
  output logic                  linear_rail_a_on,
  output logic                  rail_a_pwm_force,
  output logic                  rail_b_pwm_force,
  output logic                  rail_a_use_sleep,
  output logic                  rail_b_use_sleep,
  output logic                  linear_a_use_sleep
);

  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    logic [2:0][7:0]     ctrl;
    logic [7:0]          rdata;
    logic                rvalid;
    rcr_pkg::rcr_phase_t phase;
    logic [2:0]          on;
    logic [2:0]          pwm;
    logic [2:0]          slp;
  } rcr_state_t;

  rcr_state_t         st_r;
  rcr_state_t         st_nxt;
  rcr_pkg::rcr_rail_t rail [3];
  logic [1:0]         idx;
  logic               hit;

  // address decode, unmapped reads return zero
  always_comb begin
    hit = 1'b1;
    idx = 2'h0;
    case (req.addr)
      `RCR_OFF_STEP_A:   idx = 2'h0;
      `RCR_OFF_STEP_B:   idx = 2'h1;
      `RCR_OFF_LINEAR_A: idx = 2'h2;
      default:           hit = 1'b0;
    endcase
  end

  // ****************************************************
  // rail decode, one instance per rail
  // ****************************************************
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_rail
      rcr_rail_sel u_sel (
        .ctrl          (st_r.ctrl[g]),
        .has_mode      (g != 2),
        .pin_sel       (PIN_SEL[g]),
        .sleep_pin_one (sleep_pin_one),
        .sleep_pin_two (sleep_pin_two),
        .pin_on        (control_pin_on[g]),
        .rail          (rail[g])
      );
    end
  endgenerate

  // next state; reserved bit patterns are the host's job, stored as written
  always_comb begin
    st_nxt        = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.phase  = rcr_pkg::RCR_IDLE;
    if (req.wr && hit) begin
      st_nxt.phase = rcr_pkg::RCR_WRITE;
      st_nxt.ctrl[idx] = req.wdata & ~`RCR_RO_MASK;
    end else if (req.rd && !req.wr) begin // any write request wins
      st_nxt.phase  = rcr_pkg::RCR_READ;
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = hit ? st_r.ctrl[idx] : 8'h00;
    end
    for (int i = 0; i < 3; i++) begin
      st_nxt.on[i]  = rail[i].on;
      st_nxt.pwm[i] = rail[i].pwm;
      st_nxt.slp[i] = rail[i].use_sleep;
    end
  end

  // register everything; factory values load at reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_r         <= '0;
      st_r.ctrl[0] <= RST_STEP_A & ~`RCR_RO_MASK;
      st_r.ctrl[1] <= RST_STEP_B & ~`RCR_RO_MASK;
      st_r.ctrl[2] <= RST_LINEAR_A & ~`RCR_RO_MASK;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata               = st_r.rdata;
  assign rvalid              = st_r.rvalid;
  assign step_down_rail_a_on = st_r.on[0];
  assign step_down_rail_b_on = st_r.on[1];
  assign linear_rail_a_on    = st_r.on[2];
  assign rail_a_pwm_force    = st_r.pwm[0];
  assign rail_b_pwm_force    = st_r.pwm[1];
  assign rail_a_use_sleep    = st_r.slp[0];
  assign rail_b_use_sleep    = st_r.slp[1];
  assign linear_a_use_sleep  = st_r.slp[2];

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // top bits of every rail stay clear
  chk_ro_bits_zero: assert property (
    (st_r.ctrl[0][7:6] == 2'h0) && (st_r.ctrl[1][7:6] == 2'h0) &&
    (st_r.ctrl[2][7:6] == 2'h0))
    else $error("read-only bits nonzero");
  // off write wins two cycles later
  chk_off_wins: assert property (
    (req.wr && req.addr == `RCR_OFF_STEP_A && !req.wdata[0])
      |=> ##1 !step_down_rail_a_on)
    else $error("rail a not off after disable");
  // same for rail b
  chk_b_off: assert property (
    (req.wr && req.addr == `RCR_OFF_STEP_B && !req.wdata[0])
      |=> ##1 !step_down_rail_b_on)
    else $error("rail b not off after disable");
  // same for the linear rail
  chk_lin_off: assert property (
    (req.wr && req.addr == `RCR_OFF_LINEAR_A && !req.wdata[0])
      |=> ##1 !linear_rail_a_on)
    else $error("linear rail not off");
  // on output is the stored bit gated by its pin
  chk_a_on_gate: assert property (
    1'b1 |=> step_down_rail_a_on ==
      ($past(st_r.ctrl[0][0]) & $past(control_pin_on[0])))
    else $error("rail a on gate wrong");
  // linear on output gated the same way
  chk_lin_on_gate: assert property (
    1'b1 |=> linear_rail_a_on ==
      ($past(st_r.ctrl[2][0]) & $past(control_pin_on[2])))
    else $error("linear on gate wrong");
  // field 00 never picks the sleep code
  chk_normal_code: assert property (
    (st_r.ctrl[1][5:4] == 2'h0) |=> !rail_b_use_sleep)
    else $error("sleep code with field 00");
  // field 11 and pin low picks the sleep code
  chk_sleep_code: assert property (
    (st_r.ctrl[0][5:4] == 2'h3 && !PIN_SEL[0] && !sleep_pin_one)
      |=> rail_a_use_sleep)
    else $error("sleep code not used");
  // same for the linear rail
  chk_lin_sleep: assert property (
    (st_r.ctrl[2][5:4] == 2'h3 && !PIN_SEL[2] && !sleep_pin_one)
      |=> linear_a_use_sleep)
    else $error("linear sleep code not used");
  // mode bit follows into the force output
  chk_pwm_mode: assert property (
    $changed(st_r.ctrl[0][1]) |=> rail_a_pwm_force == $past(st_r.ctrl[0][1]))
    else $error("pwm force mismatch");
  // rail b force output tracks its bit every cycle
  chk_b_pwm_mode: assert property (
    1'b1 |=> rail_b_pwm_force == $past(st_r.ctrl[1][1]))
    else $error("rail b pwm force mismatch");
  // read of 26h returns rail a
  chk_map_a_read: assert property (
    (req.rd && !req.wr && req.addr == `RCR_OFF_STEP_A)
      |=> rvalid && rdata == $past(st_r.ctrl[0]))
    else $error("rail a readback wrong");
  // read outside the map returns zero
  chk_unmapped_zero: assert property (
    (req.rd && !req.wr && !hit) |=> rvalid && rdata == 8'h00)
    else $error("unmapped read not zero");
  // write of 27h lands in rail b
  chk_map_b_write: assert property (
    (req.wr && req.addr == `RCR_OFF_STEP_B)
      |=> st_r.ctrl[1] == ($past(req.wdata) & 8'h3F))
    else $error("rail b write lost");
  // read data holds until the next read
  chk_rdata_hold: assert property (
    !(req.rd && !req.wr) |=> $stable(rdata))
    else $error("read data changed without a read");
  // pin two high keeps rail b on its normal code
  chk_pin_fixed: assert property (
    (PIN_SEL[1] && st_r.ctrl[1][5:4] == 2'h3 && sleep_pin_two)
      |=> !rail_b_use_sleep)
    else $error("wrong sleep pin");

  // ****************************************************
  // coverage of the main scenarios
  // ****************************************************
  cov_write: cover property (st_r.phase == rcr_pkg::RCR_WRITE);
  cov_read: cover property (rvalid);
  cov_sleep: cover property (linear_a_use_sleep);
  cov_both_pwm: cover property (rail_a_pwm_force && rail_b_pwm_force);
  cov_rail_off: cover property (!step_down_rail_a_on && step_down_rail_b_on);

endmodule // rcr_bank
`default_nettype wire

// [bench/rcr_host.sv]
// host model that issues register requests to the rail control bank
`timescale 1ns/1ps
`default_nettype none
module rcr_host (
  input  wire logic         clock,
  input  wire logic [7:0]   rdata,
  input  wire logic         rvalid,
  output var rcr_pkg::rcr_req_t req
);
  initial req = '0;
  // clean sleep code and reserved patterns
  function automatic logic [7:0] legal(input logic [7:0] a,
                                       input logic [7:0] d);
    logic [7:0] f;
    f = d;
    if (^d[5:4]) f[5:4] = 2'h0;
    if (a == 8'h28) f[3:1] = 3'h6;
    else f[3:2] = 2'h3;
    return f;
  endfunction
  // one cycle request; idle lines show the inverse, never a stale value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1 req = '{1'b1, 1'b0, a, legal(a, d)};
    @(posedge clock);
    #1 req = '{1'b0, 1'b0, ~a, ~d};
  endtask
  // read waits a bounded time for the valid pulse
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge clock);
    #1 req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock);
    #1 req = '{1'b0, 1'b0, ~a, 8'hFF};
    for (n = 0; n < 3 && rvalid !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    d = (rvalid === 1'b1) ? rdata : 8'hXX;
  endtask
endmodule // rcr_host
`default_nettype wire

// [bench/tb_rail_control_registers.sv]
// self-checking bench for the rail control register bank
`timescale 1ns/1ps
`default_nettype none
`include "rcr_map.svh"
module tb_rail_control_registers;
  logic              clock = 1'b0;
  logic              rst_n = 1'b0;
  logic              pin_one = 1'b1;
  logic              pin_two = 1'b1;
  logic [2:0]        pin_on = 3'h7;
  logic [7:0]        rdata;
  logic              rvalid;
  logic [7:0]        rails;
  rcr_pkg::rcr_req_t req;
  int                mismatches = 0;
  int                check_count = 0;
  always #5 clock = ~clock;
  rcr_host u_host (.clock(clock), .rdata(rdata), .rvalid(rvalid), .req(req));
  // rail b governed by pin two, the others by pin one
  rcr_bank #(.PIN_SEL(3'h2)) u_dut (
    .clock(clock), .rst_n(rst_n), .req(req), .sleep_pin_one(pin_one),
    .sleep_pin_two(pin_two), .control_pin_on(pin_on), .rdata(rdata),
    .rvalid(rvalid), .step_down_rail_a_on(rails[7]),
    .step_down_rail_b_on(rails[6]), .linear_rail_a_on(rails[5]),
    .rail_a_pwm_force(rails[4]), .rail_b_pwm_force(rails[3]),
    .rail_a_use_sleep(rails[2]), .rail_b_use_sleep(rails[1]),
    .linear_a_use_sleep(rails[0]));
  // ****************************************
  // compare and helper tasks
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(a, d);
    check(d, exp);
  endtask
  // rail outputs land two cycles after a write, three gives margin
  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic t_reset;
    rchk(`RCR_OFF_STEP_A, `RCR_RST_STEP_A);
    rchk(`RCR_OFF_STEP_B, `RCR_RST_STEP_B);
    rchk(`RCR_OFF_LINEAR_A, `RCR_RST_LINEAR_A);
    check(rails, 8'hF0);
  endtask
  // mid-run reset brings the factory values back
  task automatic t_rerst;
    u_host.wr(`RCR_OFF_STEP_B, 8'h3E);
    @(posedge clock);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge clock);
    #1 rst_n = 1'b1;
    rchk(`RCR_OFF_STEP_B, `RCR_RST_STEP_B);
    check(rails, 8'hF0);
  endtask
  task automatic t_ro;
    u_host.wr(`RCR_OFF_STEP_A, 8'hFF);
    rchk(`RCR_OFF_STEP_A, 8'h3F);
    rchk(8'h30, 8'h00);
  endtask
  task automatic t_sleep;
    u_host.wr(`RCR_OFF_STEP_A, 8'h3D);
    u_host.wr(`RCR_OFF_STEP_B, 8'h3D);
    u_host.wr(`RCR_OFF_LINEAR_A, 8'h3D);
    pin_one = 1'b0;
    settle;
    check(rails, 8'hE5);
    pin_one = 1'b1;
    pin_two = 1'b0;
    settle;
    check(rails, 8'hE2);
    u_host.wr(`RCR_OFF_STEP_B, 8'h0D);
    settle;
    check(rails, 8'hE0);
    pin_two = 1'b1;
  endtask
  task automatic t_mode_on;
    u_host.wr(`RCR_OFF_STEP_A, 8'h0E);
    u_host.wr(`RCR_OFF_STEP_B, 8'h0F);
    u_host.wr(`RCR_OFF_LINEAR_A, 8'h0C);
    settle;
    check(rails, 8'h58);
    pin_on = 3'h5;
    u_host.wr(`RCR_OFF_LINEAR_A, 8'h0D);
    settle;
    check(rails, 8'h38);
    pin_on = 3'h7;
  endtask
  task automatic stop_test;
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // reset for ten cycles, then each scenario in turn
  initial begin
    repeat (10) @(posedge clock);
    #1 rst_n = 1'b1;
    t_reset;
    t_ro;
    t_sleep;
    t_mode_on;
    t_rerst;
    stop_test;
  end
  // watchdog well beyond the sixty or so cycles the scenarios need
  initial begin
    #20000;
    mismatches++;
    stop_test;
  end
endmodule // tb_rail_control_registers
`default_nettype wire
